// *** rtl/csd_pkg.sv ***
// package for the compare-skip and decimal-adjust execution block
// Summary of operation
// - a word whose top bits are 0110 010 decodes as compare_skip_greater, bit 8 is the access bit, bits 7:0 the file address.
// - compare_skip_greater skips when the unsigned file byte, by subtraction, is strictly above the working_register.
// - a word whose top bits are 0110 000 decodes as compare_skip_less, bit 8 access bit, bits 7:0 file address.
// - compare_skip_less skips when the unsigned file byte is strictly below the working_register, else runs on.
// - a taken skip discards the fetched next word and runs a no-operation cycle, so the compare takes two cycles.
// - a skip over a two-word instruction costs three cycles in all; no skip costs one.
// - every extra skip cycle does nothing in all four quarter phases, one cycle per skipped word.
// - the compares never touch any arithmetic status flag.
// - access bit 0 picks the access bank, access bit 1 lets the bank_select_register pick the bank.
// - with the extended set on, access bit 0 and file address up to 95, compare_skip_greater uses indexed literal offset.
// - decimal_adjust_working adds 6 per nibble on digit>9 or carry in, and updates only the carry flag.
package csd_pkg;
    // opcode patterns
    localparam logic [6:0] CSD_OPC_GT = 7'h32;          // 0110 010
    localparam logic [6:0] CSD_OPC_LT = 7'h30;          // 0110 000
    localparam logic [15:0] CSD_OPC_ADJ = 16'h0007;
    // field positions
    localparam int CSD_OPC_MSB = 15;
    localparam int CSD_OPC_LSB = 9;
    localparam int CSD_ABIT = 8;
    // addressing
    localparam logic [7:0] CSD_IDX_LIMIT = 8'h5F;       // 95
    localparam logic [7:0] CSD_ACC_SPLIT = 8'h80;
    localparam logic [3:0] CSD_ACC_LO_BANK = 4'h0;
    localparam logic [3:0] CSD_ACC_HI_BANK = 4'hF;
    // two-word instruction leaders
    localparam logic [3:0] CSD_TWO_NIB = 4'hC;
    localparam logic [5:0] CSD_TWO_TOP6 = 6'h3B;        // 1110 11xx
    // decimal adjust
    localparam logic [4:0] CSD_BCD_MAX = 5'h09;
    localparam logic [4:0] CSD_BCD_FIX = 5'h06;
    // skip lengths in instruction cycles
    localparam logic [1:0] CSD_NOP_ONE = 2'h1;
    localparam logic [1:0] CSD_NOP_TWO = 2'h2;

    typedef enum logic [1:0] {CSD_Q1, CSD_Q2, CSD_Q3, CSD_Q4} csd_phase_t;
    typedef enum logic [1:0] {CSD_OP_NONE, CSD_OP_GT, CSD_OP_LT, CSD_OP_ADJ} csd_op_t;
endpackage

// *** rtl/csd_core.sv ***
// compare-skip and decimal-adjust execution logic on the quarter-phase clock
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module csd_core
    import csd_pkg::*;
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // instruction words from the fetch stage
    input wire logic [15:0] i_instr,
    input wire logic [15:0] i_next_instr,
    // mode and bank state
    input wire logic i_ext_set_en,
    input wire logic [3:0] i_bank_select_register,
    input wire logic [11:0] i_index_base,
    // operands and flags
    input wire logic [7:0] i_file_data,
    input wire logic [7:0] i_working_register,
    input wire logic i_carry_flag,
    input wire logic i_digit_carry_flag,
    // phase and sequencing
    output logic [1:0] o_phase,
    output logic o_cycle_end,
    output logic o_nop_active,
    output logic o_skip,
    // data memory read
    output logic [11:0] o_data_addr,
    output logic o_data_rd,
    output logic o_indexed,
    // result writes
    output logic o_working_register_wr,
    output logic [7:0] o_working_register_data,
    output logic o_carry_wr,
    output logic o_carry_flag
);
    typedef struct packed {
        csd_phase_t phase;
        csd_op_t op;
        logic [7:0] faddr;
        logic abit;
        logic [7:0] fdata;
        logic [1:0] nop_cnt;
        logic cycle_end;
        logic nop_active;
        logic skip;
        logic [11:0] addr;
        logic data_rd;
        logic indexed;
        logic work_wr;
        logic [7:0] work_data;
        logic carry_wr;
        logic carry;
    } csd_state_t;

    csd_state_t st_q;
    csd_state_t st_d;

    function automatic csd_op_t decode(input logic [15:0] w);
        csd_op_t r;
        r = CSD_OP_NONE;
        if (w[CSD_OPC_MSB:CSD_OPC_LSB] == CSD_OPC_GT) begin
            r = CSD_OP_GT;
        end else if (w[CSD_OPC_MSB:CSD_OPC_LSB] == CSD_OPC_LT) begin
            r = CSD_OP_LT;
        end else if (w == CSD_OPC_ADJ) begin
            r = CSD_OP_ADJ;
        end
        return r;
    endfunction

    // leaders of the two-word forms; the second word itself never needs decoding here
    function automatic logic is_two_word(input logic [15:0] w);
        return (w[15:12] == CSD_TWO_NIB) || (w[15:10] == CSD_TWO_TOP6);
    endfunction

    // operand address from access bit, bank and mode
    function automatic logic [11:0] file_addr(input logic [7:0] f, input logic a, input logic idx,
                                              input logic [3:0] bank, input logic [11:0] base);
        logic [11:0] r;
        r = {bank, f};
        if (idx) begin
            r = base + {4'h0, f};
        end else if (!a) begin
            if (f < CSD_ACC_SPLIT) begin
                r = {CSD_ACC_LO_BANK, f};
            end else begin
                r = {CSD_ACC_HI_BANK, f};
            end
        end
        return r;
    endfunction

    // file byte minus working_register, widened so bit 8 is the borrow
    function automatic logic [8:0] sub_file_work(input logic [7:0] f, input logic [7:0] w);
        return {1'b0, f} - {1'b0, w};
    endfunction

    // nibble adjust: low nibble then high nibble with the low carry folded in
    function automatic logic [8:0] bcd_adjust(input logic [7:0] w, input logic dig_c, input logic c);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, w[3:0]};
        if (lo > CSD_BCD_MAX || dig_c) begin
            lo = lo + CSD_BCD_FIX;
        end
        hi = {1'b0, w[7:4]} + {4'h0, lo[4]};
        if (hi > CSD_BCD_MAX || c) begin
            hi = hi + CSD_BCD_FIX;
        end
        // carry is sticky once set, as the decimal carry must survive the adjust
        return {hi[4] | c, hi[3:0], lo[3:0]};
    endfunction

    always_comb begin
        logic idx;
        logic take;
        logic [8:0] adj;
        logic [8:0] diff;
        idx = 1'b0;
        take = 1'b0;
        adj = 9'h000;
        diff = 9'h000;
        st_d = st_q;
        st_d.cycle_end = 1'b0;
        st_d.skip = 1'b0;
        st_d.data_rd = 1'b0;
        st_d.work_wr = 1'b0;
        st_d.carry_wr = 1'b0;
        case (st_q.phase)
            CSD_Q1: begin
                st_d.phase = CSD_Q2;
                if (st_q.nop_cnt != 2'h0) begin
                    // discarded word: nothing happens in any phase
                    st_d.op = CSD_OP_NONE;
                    st_d.nop_active = 1'b1;
                end else begin
                    st_d.nop_active = 1'b0;
                    st_d.op = decode(i_instr);
                    st_d.faddr = i_instr[7:0];
                    st_d.abit = i_instr[CSD_ABIT];
                end
            end
            CSD_Q2: begin
                st_d.phase = CSD_Q3;
                if (st_q.op == CSD_OP_GT || st_q.op == CSD_OP_LT) begin
                    idx = i_ext_set_en && !st_q.abit && (st_q.faddr <= CSD_IDX_LIMIT)
                          && (st_q.op == CSD_OP_GT);
                    st_d.indexed = idx;
                    st_d.addr = file_addr(st_q.faddr, st_q.abit, idx, i_bank_select_register, i_index_base);
                    st_d.data_rd = 1'b1;
                end
            end
            CSD_Q3: begin
                st_d.phase = CSD_Q4;
                st_d.fdata = i_file_data;
            end
            default: begin
                st_d.phase = CSD_Q1;
                st_d.cycle_end = 1'b1;
                st_d.indexed = 1'b0;
                if (st_q.nop_cnt != 2'h0) begin
                    st_d.nop_cnt = st_q.nop_cnt - 2'h1;
                end
                diff = sub_file_work(st_q.fdata, i_working_register);
                case (st_q.op)
                    CSD_OP_GT: begin
                        // no borrow and a nonzero difference: file byte above working_register
                        take = !diff[8] && (diff[7:0] != 8'h00);
                    end
                    CSD_OP_LT: begin
                        // a borrow: file byte below working_register
                        take = diff[8];
                    end
                    CSD_OP_ADJ: begin
                        adj = bcd_adjust(i_working_register, i_digit_carry_flag, i_carry_flag);
                        st_d.work_wr = 1'b1;
                        st_d.work_data = adj[7:0];
                        st_d.carry_wr = 1'b1;
                        st_d.carry = adj[8];
                    end
                    default: begin
                        take = 1'b0;
                    end
                endcase
                // compares never raise a flag write, taken or not
                if (take) begin
                    st_d.skip = 1'b1;
                    st_d.nop_cnt = is_two_word(i_next_instr) ? CSD_NOP_TWO : CSD_NOP_ONE;
                end
            end
        endcase
        if (!i_nrst) begin
            st_d = '0;
            st_d.phase = CSD_Q1;
            st_d.op = CSD_OP_NONE;
        end
    end

    always_ff @(posedge i_clock) begin
        st_q <= st_d;
    end

    assign o_phase = st_q.phase;
    assign o_cycle_end = st_q.cycle_end;
    assign o_nop_active = st_q.nop_active;
    assign o_skip = st_q.skip;
    assign o_data_addr = st_q.addr;
    assign o_data_rd = st_q.data_rd;
    assign o_indexed = st_q.indexed;
    assign o_working_register_wr = st_q.work_wr;
    assign o_working_register_data = st_q.work_data;
    assign o_carry_wr = st_q.carry_wr;
    assign o_carry_flag = st_q.carry;
endmodule // csd_core

// *** tb/csd_core_chk.sv ***
// timing checker for the compare-skip and decimal-adjust block
`timescale 1ns/1ps
module csd_core_chk (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_nrst,
    // watched outputs
    input wire logic [1:0] o_phase,
    input wire logic o_cycle_end,
    input wire logic o_nop_active,
    input wire logic o_skip,
    input wire logic o_data_rd,
    input wire logic o_working_register_wr,
    input wire logic o_carry_wr
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    a_rd_in_q3: assert property (o_data_rd |-> o_phase == 2'h2) else $error("read outside Q3");
    a_phase_step: assert property ($past(i_nrst) |-> o_phase == 2'($past(o_phase) + 2'h1))
        else $error("phase did not advance");
    a_end_period: assert property (o_cycle_end |=> !o_cycle_end [*3] ##1 o_cycle_end)
        else $error("cycle end spacing wrong");
    a_skip_at_end: assert property (o_skip |-> o_cycle_end && o_phase == 2'h0) else $error("skip off cycle end");
    a_skip_nop: assert property (o_skip |=> o_nop_active) else $error("skip without discard");
    a_nop_len: assert property ($rose(o_nop_active) |-> o_nop_active [*4]) else $error("discard too short");
    a_nop_quiet: assert property (o_nop_active |-> !o_data_rd && !o_skip && !o_working_register_wr)
        else $error("activity in discarded cycle");
    a_cmp_flags: assert property (o_data_rd |-> ##2 o_cycle_end && !o_carry_wr && !o_working_register_wr)
        else $error("compare wrote a flag");
    a_adj_pair: assert property (o_working_register_wr |-> o_carry_wr && o_cycle_end)
        else $error("adjust write unpaired");
endmodule // csd_core_chk
bind csd_core csd_core_chk u_chk (.i_clock, .i_nrst, .o_phase, .o_cycle_end, .o_nop_active, .o_skip,
    .o_data_rd, .o_working_register_wr, .o_carry_wr);

// *** tb/tb_top.sv ***
// self-checking testbench for the compare-skip and decimal-adjust block
`timescale 1ns/1ps
module tb_top;
    import csd_pkg::*;
    logic i_clock = 0, i_nrst = 0, i_ext_set_en = 0, i_carry_flag = 0, i_digit_carry_flag = 0;
    logic [15:0] i_instr = 16'h0000, i_next_instr = 16'h0000;
    logic [3:0] i_bank_select_register = 4'h5;
    logic [11:0] i_index_base = 12'h300, o_data_addr;
    logic [7:0] i_file_data = 8'h00, i_working_register = 8'h00, o_working_register_data;
    logic [1:0] o_phase;
    logic o_cycle_end, o_nop_active, o_skip, o_data_rd, o_indexed, o_working_register_wr, o_carry_wr, o_carry_flag;
    int error_cnt = 0, n_tests = 0;
    always #5 i_clock = ~i_clock;
    csd_core dut (.i_clock, .i_nrst, .i_instr, .i_next_instr, .i_ext_set_en, .i_bank_select_register,
        .i_index_base, .i_file_data, .i_working_register, .i_carry_flag, .i_digit_carry_flag, .o_phase,
        .o_cycle_end, .o_nop_active, .o_skip, .o_data_addr, .o_data_rd, .o_indexed,
        .o_working_register_wr, .o_working_register_data, .o_carry_wr, .o_carry_flag);
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    // one instruction, then a 12-clock window counting discarded clocks
    task automatic run(input logic [15:0] ins, nxt, input logic [7:0] f, w, input logic [11:0] adr,
            input logic idx, input int nops);
        int cnt;
        logic cmp, wr;
        cnt = 0;
        wr = 0;
        cmp = (ins != CSD_OPC_ADJ);
        while (o_phase !== 2'h3) begin
            @(posedge i_clock);
            #1;
        end
        @(posedge i_clock);
        i_instr <= ins;
        i_next_instr <= nxt;
        i_file_data <= f;
        i_working_register <= w;
        repeat (2) @(posedge i_clock);
        #1 chk(o_data_rd === cmp, "read strobe");
        if (cmp) chk(o_data_addr === adr && o_indexed === idx, "operand address");
        // a refused adjust rides in the discarded slot
        @(posedge i_clock) i_instr <= (nops > 0) ? CSD_OPC_ADJ : 16'h0000;
        @(posedge i_clock) #1 chk(o_cycle_end === 1'b1 && o_skip === (nops > 0), "skip decision");
        chk(o_working_register_wr === !cmp && o_carry_wr === !cmp, "result write");
        for (int k = 0; k < 12; k++) begin
            @(posedge i_clock) if (k == 2) i_instr <= 16'h0000;
            #1 cnt += (o_nop_active === 1'b1);
            wr |= (o_working_register_wr === 1'b1);
        end
        chk(cnt == 4 * nops && !wr, "discarded clocks");
    endtask
    task automatic sc_greater;
        run(16'h6410, 16'h0000, 8'h42, 8'h42, 12'h010, 0, 0);
        run(16'h6510, 16'h0000, 8'h43, 8'h42, 12'h510, 0, 1);
        run(16'h6590, 16'hC123, 8'hFF, 8'h00, 12'h590, 0, 2);
        run(16'h6490, 16'hEC00, 8'h80, 8'h7F, 12'hF90, 0, 2);
        run(16'h64FF, 16'hE800, 8'h01, 8'h00, 12'hFFF, 0, 1);
    endtask
    task automatic sc_less;
        run(16'h6020, 16'h0000, 8'h10, 8'h11, 12'h020, 0, 1);
        run(16'h6020, 16'hEF00, 8'h00, 8'hFF, 12'h020, 0, 2);
        run(16'h6120, 16'h0000, 8'h80, 8'h7F, 12'h520, 0, 0);
        run(16'h6020, 16'h0000, 8'h11, 8'h11, 12'h020, 0, 0);
    endtask
    task automatic sc_indexed;
        i_ext_set_en <= 1'b1;
        run(16'h645F, 16'h0000, 8'h01, 8'h01, 12'h35F, 1, 0);
        run(16'h6460, 16'h0000, 8'h01, 8'h01, 12'h060, 0, 0);
        run(16'h655F, 16'h0000, 8'h01, 8'h01, 12'h55F, 0, 0);
        run(16'h605F, 16'h0000, 8'h01, 8'h01, 12'h05F, 0, 0);
        i_ext_set_en <= 1'b0;
    endtask
    // expected carry and working_register worked out by hand, nibble by nibble
    task automatic sc_adjust(input logic [7:0] w, input logic c, input logic dig_c, input logic [8:0] exp_cw);
        i_carry_flag <= c;
        i_digit_carry_flag <= dig_c;
        run(CSD_OPC_ADJ, 16'h0000, 8'h00, w, 12'h000, 0, 0);
        chk({o_carry_flag, o_working_register_data} === exp_cw, "adjusted value");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge i_clock);
        i_nrst <= 1'b1;
        sc_greater();
        sc_less();
        sc_indexed();
        sc_adjust(8'hA5, 0, 0, 9'h105);
        sc_adjust(8'h19, 0, 1, 9'h01F);
        sc_adjust(8'h9A, 0, 0, 9'h100);
        sc_adjust(8'h12, 1, 0, 9'h172);
        complete_run();
    end
    // about 350 clocks of tests; 10000 clocks leaves a wide margin
    initial begin
        #100000;
        error_cnt++;
        complete_run();
    end
endmodule // tb_top
